// ---- common/sspt_pkg.sv ----
// Shared constants and carriers for the security sector and parameter table block
package sspt_pkg;
    // Command opcodes
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_READ_TABLE = 8'h5A;
    // Frame bit positions
    localparam logic [15:0] HDR_BITS = 16'h0020;
    localparam logic [15:0] DATA_BITS = 16'h0028;
    localparam logic [15:0] FIRST_BYTE_END = 16'h0027;
    localparam logic [15:0] OP_LAST_BIT = 16'h0007;
    localparam logic [15:0] ADDR_LAST_BIT = 16'h001F;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] RSVD_BYTE = 8'hFF;
    localparam int SEC_BYTES = 1024;
    localparam int PAGE_BYTES = 256;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int SECTOR_ERASE_TIME_US = 300;
    localparam int PROG_TIME_US = 3;
    localparam int ERASE_CYC_DEF = SECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYC_DEF = PROG_TIME_US * CLK_MHZ;
    // Parameter table contents, address in the upper byte
    localparam int PT_N = 18;
    localparam logic [15:0] PT_TABLE [PT_N] = '{
        16'h8B6B,
        16'h8C08, 16'h8D3B,
        16'h8E80, 16'h8FBB,
        16'h90FE,
        16'h9600, 16'h9700,
        16'h9A08, 16'h9BEB,
        16'h9C0C, 16'h9D20, 16'h9E0F, 16'h9F52, 16'hA010, 16'hA1D8,
        16'hA200, 16'hA300
    };
    // Summary of the last frame seen on the link
    typedef struct packed {
        logic seq;
        logic [7:0] op;
        logic [15:0] bits;
        logic [23:0] addr;
    } sspt_frame_t;
    // One received program byte
    typedef struct packed {
        logic [7:0] col;
        logic [7:0] data;
    } sspt_byte_t;
endpackage

// ---- rtl/sspt_param_rom.sv ----
// Parameter table lookup, reserved bytes read as all ones
`timescale 1ns/1ps
module sspt_param_rom
    import sspt_pkg::*;
(
    input wire logic [7:0] addr,
    output logic [7:0] data
);
    always_comb
    begin
        data = RSVD_BYTE;
        for (int i = 0; i < PT_N; i++)
        begin
            if (PT_TABLE[i][15:8] == addr)
            begin
                data = PT_TABLE[i][7:0];
            end
        end
    end
endmodule // sspt_param_rom

// ---- rtl/sspt_sec_mem.sv ----
// Single port byte memory with registered read data
`timescale 1ns/1ps
module sspt_sec_mem
    import sspt_pkg::*;
#(
    parameter int DEPTH = SEC_BYTES,
    parameter int AW = 10
)
(
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_ff
);
    logic [7:0] mem [DEPTH];

    // Read first, read returns old contents
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata_ff <= mem[addr];
    end
endmodule // sspt_sec_mem

// ---- rtl/sspt_top.sv ----
// Security sector erase/program and parameter table read on the serial link
`timescale 1ns/1ps
module sspt_top
    import sspt_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_CYC_DEF,
    parameter int PROG_CYC = PROG_CYC_DEF
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic wel_set,
    input wire logic security_lock_bit,
    output logic write_enable_latch,
    output logic write_in_progress
);
    typedef enum logic [2:0] {S_IDLE, S_ERASE, S_PRD, S_PWR, S_WAIT} sspt_state_t;

    // Link domain
    logic [15:0] cnt_ff;
    logic [31:0] sh_ff;
    sspt_frame_t frm_ff;
    sspt_byte_t bev_ff;
    logic btgl_ff;
    logic sdo_ff;
    logic sdo_oe_ff;
    logic [15:0] rd_idx;
    logic [7:0] rom_addr;
    logic [7:0] rom_data;
    logic [7:0] in_byte;

    // Core domain
    sspt_state_t state_ff;
    logic cs_meta_ff, cs_sync_ff, cs_prev_ff;
    logic bt_meta_ff, bt_sync_ff, bt_seen_ff;
    logic seen_seq_ff;
    logic wel_ff, wip_ff;
    logic [9:0] walk_ff;
    logic [1:0] page_ff;
    logic [31:0] tmr_ff;
    logic [10:0] erase_len_ff;
    logic [PAGE_BYTES-1:0] touched_ff;
    logic cs_rise, new_frame, idle, erase_ok, prog_ok, bev_take, done;
    logic sec_we, buf_we;
    logic [9:0] sec_addr;
    logic [7:0] buf_addr, sec_wdata, sec_rd, buf_rd;

    assign in_byte = {sh_ff[6:0], serial_data_in};

    // Bit counter restarts with every frame
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            cnt_ff <= 16'h0000;
        else if (cnt_ff != 16'hFFFF)
            cnt_ff <= cnt_ff + 16'h0001;
    end

    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
            sh_ff <= 32'h0000_0000;
        else
            sh_ff <= {sh_ff[30:0], serial_data_in};
    end

    // Frame summary survives select rising so the core can read it later
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
            frm_ff <= '0;
        else
        begin
            if (cnt_ff == 16'h0000)
                frm_ff.seq <= ~frm_ff.seq;
            if (cnt_ff == OP_LAST_BIT)
                frm_ff.op <= in_byte;
            if (cnt_ff == ADDR_LAST_BIT)
                frm_ff.addr <= {sh_ff[22:0], serial_data_in};
            frm_ff.bits <= cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            bev_ff <= '0;
            btgl_ff <= 1'b0;
        end
        else if (frm_ff.op == OP_SEC_PROG && cnt_ff >= FIRST_BYTE_END && cnt_ff[2:0] == 3'h7)
        begin
            bev_ff.data <= in_byte;
            bev_ff.col <= frm_ff.addr[7:0] + 8'((cnt_ff - FIRST_BYTE_END) >> 3);
            btgl_ff <= ~btgl_ff; // Data held 8 serial clocks, ample for the crossing
        end
    end

    assign rd_idx = cnt_ff - DATA_BITS;
    assign rom_addr = frm_ff.addr[7:0] + rd_idx[10:3];

    sspt_param_rom u_rom
    (
        .addr(rom_addr),
        .data(rom_data)
    );

    // Table bytes leave MSB first on the falling edge
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end
        else if (frm_ff.op == OP_READ_TABLE && cnt_ff >= DATA_BITS)
        begin
            sdo_oe_ff <= 1'b1;
            sdo_ff <= rom_data[~rd_idx[2:0]];
        end
    end

    assign serial_data_out = sdo_ff;
    assign serial_data_oe = sdo_oe_ff;

    // Select and byte toggle cross into the core clock
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            {cs_meta_ff, cs_sync_ff, cs_prev_ff} <= 3'h7;
            {bt_meta_ff, bt_sync_ff, bt_seen_ff} <= 3'h0;
            seen_seq_ff <= 1'b0;
        end
        else
        begin
            cs_meta_ff <= cs_n;
            cs_sync_ff <= cs_meta_ff;
            cs_prev_ff <= cs_sync_ff;
            bt_meta_ff <= btgl_ff;
            bt_sync_ff <= bt_meta_ff;
            bt_seen_ff <= bt_sync_ff;
            if (cs_rise)
                seen_seq_ff <= frm_ff.seq;
        end
    end

    assign cs_rise = cs_sync_ff & ~cs_prev_ff;
    assign new_frame = cs_rise && (frm_ff.seq != seen_seq_ff);
    assign idle = (state_ff == S_IDLE);
    assign bev_take = (bt_sync_ff != bt_seen_ff) && idle;
    assign done = (state_ff == S_WAIT) && (tmr_ff == 32'h0000_0000);

    // erase needs latch, exact address end, no lock
    assign erase_ok = new_frame && idle && frm_ff.op == OP_SEC_ERASE && frm_ff.bits == HDR_BITS
        && wel_ff && !security_lock_bit;
    // program needs latch, whole bytes, no lock
    assign prog_ok = new_frame && idle && frm_ff.op == OP_SEC_PROG && frm_ff.bits >= DATA_BITS
        && frm_ff.bits[2:0] == 3'h0 && wel_ff && !security_lock_bit;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_ff <= S_IDLE;
            walk_ff <= 10'h000;
            tmr_ff <= 32'h0000_0000;
            page_ff <= 2'h0;
        end
        else
        begin
            unique case (state_ff)
                S_IDLE:
                begin
                    walk_ff <= 10'h000;
                    if (erase_ok)
                        state_ff <= S_ERASE;
                    else if (prog_ok)
                    begin
                        state_ff <= S_PRD;
                        page_ff <= frm_ff.addr[9:8];
                    end
                end
                S_ERASE:
                begin
                    walk_ff <= walk_ff + 10'h001;
                    if (walk_ff == 10'h3FF)
                    begin
                        state_ff <= S_WAIT;
                        tmr_ff <= 32'(ERASE_CYC - 1);
                    end
                end
                S_PRD:
                    state_ff <= S_PWR;
                S_PWR:
                begin
                    walk_ff <= walk_ff + 10'h001;
                    if (walk_ff[7:0] == 8'hFF)
                    begin
                        state_ff <= S_WAIT;
                        tmr_ff <= 32'(PROG_CYC - 1);
                    end
                    else
                        state_ff <= S_PRD;
                end
                S_WAIT:
                begin
                    if (done)
                        state_ff <= S_IDLE;
                    else
                        tmr_ff <= tmr_ff - 32'h0000_0001;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wel_ff <= 1'b0;
            wip_ff <= 1'b0;
        end
        else
        begin
            if (wel_set)
                wel_ff <= 1'b1;
            else if (done)
                wel_ff <= 1'b0;
            if (erase_ok || prog_ok)
                wip_ff <= 1'b1;
            else if (done)
                wip_ff <= 1'b0;
        end
    end

    assign write_enable_latch = wel_ff;
    assign write_in_progress = wip_ff;

    // mark columns received, forget them when refused or finished
    always_ff @(posedge ref_clk)
    begin
        if (rst || done || (cs_rise && idle && !prog_ok))
            touched_ff <= '0;
        else if (bev_take)
            touched_ff[bev_ff.col] <= 1'b1;
    end

    // sector store apart from the main array
    assign sec_addr = (state_ff == S_ERASE) ? walk_ff : {page_ff, walk_ff[7:0]};
    assign sec_we = (state_ff == S_ERASE) || (state_ff == S_PWR && touched_ff[walk_ff[7:0]]);
    assign sec_wdata = (state_ff == S_ERASE) ? ERASED_BYTE : (buf_rd & sec_rd);
    assign buf_addr = (state_ff == S_PRD || state_ff == S_PWR) ? walk_ff[7:0] : bev_ff.col;
    assign buf_we = bev_take;

    sspt_sec_mem #(.DEPTH(SEC_BYTES), .AW(10)) u_sector
    (
        .clk(ref_clk),
        .we(sec_we),
        .addr(sec_addr),
        .wdata(sec_wdata),
        .rdata_ff(sec_rd)
    );

    sspt_sec_mem #(.DEPTH(PAGE_BYTES), .AW(8)) u_page_buf
    (
        .clk(ref_clk),
        .we(buf_we),
        .addr(buf_addr),
        .wdata(bev_ff.data),
        .rdata_ff(buf_rd)
    );

    wip_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
        !idle |-> wip_ff)
        else $error("busy flag low during operation");

    erase_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        erase_ok |=> state_ff == S_ERASE && wip_ff)
        else $error("erase did not start");

    // Erase length, counted since a plain delay that long is too costly
    always_ff @(posedge ref_clk)
    begin
        if (rst || state_ff != S_ERASE)
            erase_len_ff <= 11'h000;
        else
            erase_len_ff <= erase_len_ff + 11'h001;
    end

    // erase walks each sector byte once
    erase_walk_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_ff == S_ERASE |=> (state_ff == S_ERASE && erase_len_ff < 11'(SEC_BYTES))
            || (state_ff == S_WAIT && erase_len_ff == 11'(SEC_BYTES)))
        else $error("erase length wrong");

    done_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        done && !wel_set |=> !wel_ff && !wip_ff && idle)
        else $error("completion left flags set");

    lock_erase_a: assert property (@(posedge ref_clk) disable iff (rst)
        cs_rise && idle && security_lock_bit && frm_ff.op == OP_SEC_ERASE |=> idle && !wip_ff)
        else $error("erase ran while locked");

    lock_prog_a: assert property (@(posedge ref_clk) disable iff (rst)
        cs_rise && idle && security_lock_bit && frm_ff.op == OP_SEC_PROG |=> idle && !wip_ff)
        else $error("program ran while locked");

    wel_needed_a: assert property (@(posedge ref_clk) disable iff (rst)
        cs_rise && idle && !wel_ff |=> idle)
        else $error("command ran without write enable");

    erase_align_a: assert property (@(posedge ref_clk) disable iff (rst)
        cs_rise && idle && frm_ff.op == OP_SEC_ERASE && frm_ff.bits != HDR_BITS |=> idle)
        else $error("erase ran on a bad frame");

    // no bit goes from zero to one
    prog_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_ff == S_PWR && sec_we |-> (sec_wdata & ~sec_rd) == 8'h00)
        else $error("program raised a bit");

    table_byte_a: assert property (@(posedge sclk) disable iff (cs_n)
        rom_addr == 8'h8B |-> rom_data == 8'h6B)
        else $error("table byte 8Bh wrong");
endmodule // sspt_top

// ---- dv/sspt_host_model.sv ----
// Host serial controller model that drives the security sector link
`timescale 1ns/1ps
module sspt_host_model
(
    output logic sclk,
    output logic cs_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    // Half of the 64 ns link period; the clock stands still between frames
    localparam time HALF = 32ns;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // Header MSB first, then the data byte repeated; rd keeps the last 8 samples
    task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nbits,
                         input logic [7:0] dat, output logic [7:0] rd);
        logic [31:0] hdr;
        logic b;
        hdr = {op, addr};
        rd = 8'h00;
        b = 1'b0;
        #(HALF) cs_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            b = (i < 32) ? hdr[31 - i] : dat[7 - (i % 8)];
            serial_data_in = b;
            #(HALF) sclk = 1'b1;
            rd = {rd[6:0], serial_data_out};
            #(HALF) sclk = 1'b0;
        end
        // select rises after last latched bit
        #(HALF) cs_n = 1'b1;
        // Released line shows the inverse so a stale bit cannot pass
        serial_data_in = ~b;
        #(4 * HALF);
    endtask
endmodule // sspt_host_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the security sector and parameter table block
`timescale 1ns/1ps
module tb_top;
    import sspt_pkg::*;
    // Short self-timed waits keep the run brief
    localparam int ERASE_T = 4;
    localparam int PROG_T = 4;
    logic ref_clk = 1'b0;
    logic rst, sclk, cs_n, serial_data_in, serial_data_out, serial_data_oe;
    logic wel_set, security_lock_bit, write_enable_latch, write_in_progress;
    int err_count, comparisons;
    int busy_total = 0;
    int oe_edges = 0;
    logic [7:0] corner [8] = '{8'h10, 8'h7F, 8'h91, 8'h95, 8'h98, 8'h99, 8'hA4, 8'hFF};
    int lens [5] = '{1, 2, 256, 257, 5};

    // Core clock at 100 MHz
    always #5 ref_clk = ~ref_clk;

    sspt_top #(.ERASE_CYC(ERASE_T), .PROG_CYC(PROG_T)) i_sspt_top (
        .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe), .wel_set(wel_set),
        .security_lock_bit(security_lock_bit),
        .write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress));

    sspt_host_model u_host_model (
        .sclk(sclk), .cs_n(cs_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out));

    // Busy time and driven table bits, each counted on its own clock
    always @(posedge ref_clk)
    begin
        if (write_in_progress === 1'b1)
            busy_total++;
    end

    always @(posedge sclk)
    begin
        if (serial_data_oe === 1'b1)
            oe_edges++;
    end

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic results();
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wait_ref(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Expected table contents
    function automatic logic [7:0] exp_table(input logic [7:0] a);
        case (a)
            8'h8B: return 8'h6B;
            8'h8C, 8'h9A: return 8'h08;
            8'h8D: return 8'h3B;
            8'h8E: return 8'h80;
            8'h8F: return 8'hBB;
            8'h90: return 8'hFE;
            8'h96, 8'h97, 8'hA2, 8'hA3: return 8'h00;
            8'h9B: return 8'hEB;
            8'h9C: return 8'h0C;
            8'h9D: return 8'h20;
            8'h9E: return 8'h0F;
            8'h9F: return 8'h52;
            8'hA0: return 8'h10;
            8'hA1: return 8'hD8;
            default: return 8'hFF;
        endcase
    endfunction

    task automatic read_tab(input logic [7:0] a);
        logic [7:0] rd;
        int o0;
        o0 = oe_edges;
        u_host_model.frame(OP_READ_TABLE, {16'h0000, a}, 48, 8'h00, rd);
        check(rd, exp_table(a), "table byte");
        check(8'(oe_edges - o0), 8'h08, "enable not over eight bits");
        check({7'h00, serial_data_oe}, 8'h00, "enable kept after select");
    endtask

    task automatic pulse_wel();
        @(posedge ref_clk);
        #1 wel_set = 1'b1;
        @(posedge ref_clk);
        #1 wel_set = 1'b0;
        wait_ref(2);
        check({7'h00, write_enable_latch}, 8'h01, "latch not set");
    endtask

    // Send one frame; go says whether it must run, min is the least busy time
    task automatic cmd(input logic [7:0] op, input int nbits, input logic go, input int min);
        logic [7:0] rd;
        logic wel0;
        int n;
        int b0;
        wel0 = write_enable_latch;
        b0 = busy_total;
        u_host_model.frame(op, {14'h0000, 10'($urandom())}, nbits, 8'($urandom()), rd);
        n = 0;
        while (write_in_progress !== 1'b1 && n < 12)
        begin
            wait_ref(1);
            n++;
        end
        if (!go)
        begin
            check({7'h00, write_in_progress}, 8'h00, "refused command ran");
            check({7'h00, write_enable_latch}, {7'h00, wel0}, "latch changed");
        end
        else
        begin
            check({7'h00, write_in_progress}, 8'h01, "no busy flag");
            n = 0;
            while (write_in_progress === 1'b1 && n < 3000)
            begin
                wait_ref(1);
                n++;
            end
            if (n == 3000)
            begin
                err_count++;
                disable run_tests;
            end
            check({7'h00, (busy_total - b0) >= min}, 8'h01, "busy too short");
            check({7'h00, write_enable_latch}, 8'h00, "latch kept");
        end
    endtask

    task run_tests();
        err_count = 0;
        comparisons = 0;
        rst = 1'b1;
        wel_set = 1'b0;
        security_lock_bit = 1'b0;
        void'($urandom(32'h8D7D));
        repeat (6) @(posedge ref_clk);
        #1 rst = 1'b0;
        wait_ref(3);
        check({6'h00, write_enable_latch, write_in_progress}, 8'h00, "reset state");
        // Documented bytes, reserved corners, random picks from 10h to FFh
        for (int a = 8'h8B; a <= 8'hA3; a++)
            read_tab(a[7:0]);
        foreach (corner[i])
            read_tab(corner[i]);
        repeat (16)
            read_tab(8'h10 + 8'($urandom_range(8'hEF, 8'h00)));
        cmd(OP_SEC_ERASE, 32, 1'b0, 0);
        pulse_wel();
        // select raised off the byte boundary
        cmd(OP_SEC_ERASE, 31, 1'b0, 0);
        cmd(OP_SEC_ERASE, 33, 1'b0, 0);
        cmd(OP_SEC_ERASE, 32, 1'b1, 1024);
        cmd(OP_SEC_PROG, 40, 1'b0, 0);
        pulse_wel();
        // no data byte or partial byte refused
        cmd(OP_SEC_PROG, 32, 1'b0, 0);
        cmd(OP_SEC_PROG, 43, 1'b0, 0);
        // lengths up to and past one page
        foreach (lens[i])
        begin
            pulse_wel();
            cmd(OP_SEC_PROG, 32 + 8 * lens[i], 1'b1, 512);
        end
        @(posedge ref_clk);
        #1 security_lock_bit = 1'b1;
        pulse_wel();
        cmd(OP_SEC_ERASE, 32, 1'b0, 0);
        cmd(OP_SEC_PROG, 48, 1'b0, 0);
    endtask

    // The run ends here only, a timeout included
    initial
    begin
        run_tests();
        results();
    end
endmodule // tb_top
